// file: inc/mlfr_pkg.sv
package mlfr_pkg;
  // Clock rate and retry time base
  localparam int CLK_MHZ = 125; // System clock rate
  localparam int HALF_SEC_MS = 500; // Shortest retry interval, ms
  localparam int HALF_SEC_CYCLES = HALF_SEC_MS * 1000 * CLK_MHZ; // Cycles per 500 ms
  localparam int TIMER_W = 26; // Holds HALF_SEC_CYCLES
  localparam int TICK_W = 5; // Half-second ticks, up to 28

  // Configuration word layout
  localparam int INTERVAL_LSB = 7; // Retry interval field, bits 10..7
  localparam int SELECT_LSB = 3; // Stall response field, bits 6..3
  localparam int FIELD_W = 4; // Both fields are four bits
  localparam logic [31:0] CFG_RESET = 32'h0000_0000; // Value after reset
  localparam logic [31:0] CFG_MASK = 32'h0000_07f8; // Implemented bits

  // Stall response codes
  localparam logic [3:0] SEL_LATCH_HIZ = 4'h0;
  localparam logic [3:0] SEL_LATCH_RECIRC = 4'h1;
  localparam logic [3:0] SEL_LATCH_HSB = 4'h2;
  localparam logic [3:0] SEL_LATCH_LSB = 4'h3;
  localparam logic [3:0] SEL_RETRY_HIZ = 4'h4;
  localparam logic [3:0] SEL_RETRY_RECIRC = 4'h5;
  localparam logic [3:0] SEL_RETRY_HSB = 4'h6;
  localparam logic [3:0] SEL_RETRY_LSB = 4'h7;
  localparam logic [3:0] SEL_REPORT = 4'h8;

  // Interval codes with a special meaning
  localparam logic [3:0] IVL_HALF_SEC = 4'h1; // Codes 0 and 1 give one tick

  // Command to the output stage
  typedef enum logic [2:0] {
    DRV_NORMAL,
    DRV_HIZ,
    DRV_RECIRC,
    DRV_HS_BRAKE,
    DRV_LS_BRAKE
  } mlfr_drive_t;

  // Status bundle
  typedef struct packed {
    logic fault; // Fault active
    logic latched; // Fault latched, needs clear
    logic retrying; // Waiting out a retry interval
    logic reporting; // Report-only fault
  } mlfr_status_t;
endpackage : mlfr_pkg

// file: verilog/mlfr_retry_timer.sv
`timescale 1ns/1ns
module mlfr_retry_timer
  import mlfr_pkg::*;
#(
  parameter int HALF_CYC = HALF_SEC_CYCLES // Cycles per half-second tick
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, low
  input wire logic start, // Restart the interval
  input wire logic [TICK_W-1:0] ticks, // Half-second ticks to wait
  output logic done // One-cycle pulse at expiry
);
  logic [TIMER_W-1:0] pre_ff; // Prescaler within one tick
  logic [TICK_W-1:0] left_ff; // Ticks still to wait
  logic run_ff; // Interval in progress
  logic tick; // Prescaler wrap

  localparam logic [TIMER_W-1:0] PRE_LAST = TIMER_W'(HALF_CYC - 1);

  assign tick = run_ff && (pre_ff == PRE_LAST);

  // Prescaler; restarts so every interval is whole
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_ff <= '0;
    else if (start || tick)
      pre_ff <= '0;
    else if (run_ff)
      pre_ff <= pre_ff + 1'b1;
  end

  // Tick countdown and done pulse
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left_ff <= '0;
      run_ff <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        left_ff <= ticks;
        run_ff <= 1'b1;
      end
      else if (tick)
      begin
        left_ff <= left_ff - 1'b1;
        if (left_ff == TICK_W'(1))
        begin
          run_ff <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : mlfr_retry_timer

// file: verilog/mlfr_top.sv
`timescale 1ns/1ns
// What this block does
// - Retry interval field in bits 10..7
// - Code 0: latch, fault low, tristate
// - Code 1: latch, fault low, recirculate
// - Code 2: latch, fault low, high-side brake
// - Code 3: latch, fault low, low-side brake
// - Code 4: tristate, auto-clear, latch past limit
// - Code 5: as code 4, recirculating
// - Code 6: high-side brake, auto-clear up to limit
// - Code 7: low-side brake, auto-clear, latch past limit
// - Code 8: report only, stage unchanged
// - Codes 9 to F: detection disabled
module mlfr_top
  import mlfr_pkg::*;
#(
  parameter int HALF_CYC = HALF_SEC_CYCLES, // Cycles per 500 ms
  parameter int LIMIT_W = 3 // Width of the retry limit
) (
  input wire logic CLK, // System clock, 125 MHz
  input wire logic RESET_N, // Async reset, low
  input wire logic CFG_WR, // Config write strobe
  input wire logic [31:0] CFG_WDATA, // Config write data
  output logic [31:0] CFG_RDATA, // Config read-back
  input wire logic [LIMIT_W-1:0] RETRY_LIMIT, // Retries allowed before latching
  input wire logic LOCK_DET, // Motor lock detected, level
  input wire logic FAULT_CLR, // Clears a latched fault, pulse
  output logic FAULT_IND_N, // Fault indicator, low active
  output mlfr_drive_t DRIVE_CMD, // Output stage command
  output mlfr_status_t STATUS, // Fault status bundle
  output logic [LIMIT_W-1:0] RETRY_COUNT // Retries taken so far
);
  typedef enum logic [1:0] {ST_IDLE, ST_RETRY, ST_LATCHED, ST_REPORT} mlfr_state_t;

  logic [31:0] cfg_ff; // Configuration register
  logic [FIELD_W-1:0] lock_retry_interval; // Interval code
  logic [FIELD_W-1:0] stall_response_select; // Response code
  mlfr_state_t state_ff, nxt_state; // Response state
  mlfr_drive_t act_ff, nxt_act; // Stage action held while faulted
  mlfr_drive_t mode_act; // Action for current code
  logic [LIMIT_W-1:0] cnt_ff; // Retry counter
  logic [TICK_W-1:0] ticks; // Interval in half seconds
  logic start; // Launch interval timer
  logic done; // Interval elapsed
  logic is_latch, is_retry, is_report; // Code classes
  logic fault_n_ff; // Registered indicator

  assign lock_retry_interval = cfg_ff[INTERVAL_LSB +: FIELD_W];
  assign stall_response_select = cfg_ff[SELECT_LSB +: FIELD_W];

  // Config register; only the two fields are kept
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      cfg_ff <= CFG_RESET;
    else if (CFG_WR)
      cfg_ff <= CFG_WDATA & CFG_MASK;
  end

  assign CFG_RDATA = cfg_ff;

  // Code 0 is reserved; it behaves as 500 ms rather than zero time
  always_comb
  begin
    if (lock_retry_interval <= IVL_HALF_SEC)
      ticks = TICK_W'(1);
    else
      ticks = {lock_retry_interval - 4'h1, 1'b0};
  end

  // Classify the code; everything above 8 is disabled
  assign is_latch = (stall_response_select <= SEL_LATCH_LSB);
  assign is_retry = (stall_response_select >= SEL_RETRY_HIZ)
                 && (stall_response_select <= SEL_RETRY_LSB);
  assign is_report = (stall_response_select == SEL_REPORT);

  // Stage action picked by the code
  always_comb
  begin
    case (stall_response_select)
      SEL_LATCH_HIZ, SEL_RETRY_HIZ: mode_act = DRV_HIZ;
      SEL_LATCH_RECIRC, SEL_RETRY_RECIRC: mode_act = DRV_RECIRC;
      SEL_LATCH_HSB, SEL_RETRY_HSB: mode_act = DRV_HS_BRAKE;
      SEL_LATCH_LSB, SEL_RETRY_LSB: mode_act = DRV_LS_BRAKE;
      default: mode_act = DRV_NORMAL;
    endcase
  end

  // Response state machine
  always_comb
  begin
    nxt_state = state_ff;
    nxt_act = act_ff;
    start = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (LOCK_DET && is_latch)
        begin
          nxt_state = ST_LATCHED;
          nxt_act = mode_act;
        end
        else if (LOCK_DET && is_retry)
        begin
          nxt_state = ST_RETRY;
          nxt_act = mode_act;
          start = 1'b1;
        end
        else if (LOCK_DET && is_report)
          nxt_state = ST_REPORT;
      end
      ST_RETRY:
      begin
        // Past the limit the fault latches with the same stage action
        if (done && (cnt_ff >= RETRY_LIMIT))
          nxt_state = ST_LATCHED;
        else if (done)
        begin
          nxt_state = ST_IDLE;
          nxt_act = DRV_NORMAL;
        end
      end
      ST_LATCHED:
      begin
        if (FAULT_CLR)
        begin
          nxt_state = ST_IDLE;
          nxt_act = DRV_NORMAL;
        end
      end
      ST_REPORT:
      begin
        // Report lasts while the lock persists and the code stays 8
        if (!LOCK_DET || !is_report)
          nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_act = DRV_NORMAL;
      end
    endcase
  end

  // State and action registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_ff <= ST_IDLE;
      act_ff <= DRV_NORMAL;
    end
    else
    begin
      state_ff <= nxt_state;
      act_ff <= nxt_act;
    end
  end

  // Retry counter; a clear outside a retry interval restarts the budget
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      cnt_ff <= '0;
    else if (FAULT_CLR && state_ff != ST_RETRY)
      cnt_ff <= '0;
    else if (state_ff == ST_RETRY && done && cnt_ff < RETRY_LIMIT)
      cnt_ff <= cnt_ff + 1'b1;
  end

  // Indicator from the next state so it tracks the stage command
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      fault_n_ff <= 1'b1;
    else
      fault_n_ff <= (nxt_state == ST_IDLE);
  end

  mlfr_retry_timer #(
    .HALF_CYC(HALF_CYC)
  ) u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(start),
    .ticks(ticks),
    .done(done)
  );

  assign FAULT_IND_N = fault_n_ff;
  assign DRIVE_CMD = act_ff;
  assign RETRY_COUNT = cnt_ff;
  assign STATUS = '{fault: !fault_n_ff, latched: state_ff == ST_LATCHED,
                    retrying: state_ff == ST_RETRY, reporting: state_ff == ST_REPORT};

  // Checks
  property p_latch_modes;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_IDLE && LOCK_DET && is_latch) |=> (state_ff == ST_LATCHED && !FAULT_IND_N);
  endproperty
  a_latch_modes: assert property (p_latch_modes) else $error("latch code did not latch");

  property p_hiz;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_IDLE && LOCK_DET && stall_response_select == SEL_LATCH_HIZ)
      |=> DRIVE_CMD == DRV_HIZ;
  endproperty
  a_hiz: assert property (p_hiz) else $error("code 0 not tristated");

  property p_recirc;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_IDLE && LOCK_DET && stall_response_select == SEL_RETRY_RECIRC)
      |=> (DRIVE_CMD == DRV_RECIRC) throughout (state_ff == ST_RETRY)[*2];
  endproperty
  a_recirc: assert property (p_recirc) else $error("code 5 not recirculating");

  property p_hsb;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_IDLE && LOCK_DET && stall_response_select == SEL_LATCH_HSB)
      |=> DRIVE_CMD == DRV_HS_BRAKE;
  endproperty
  a_hsb: assert property (p_hsb) else $error("code 2 not braking high");

  property p_lsb;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_RETRY && act_ff == DRV_LS_BRAKE && done && cnt_ff >= RETRY_LIMIT)
      |=> (state_ff == ST_LATCHED && DRIVE_CMD == DRV_LS_BRAKE);
  endproperty
  a_lsb: assert property (p_lsb) else $error("code 7 did not latch braking");

  property p_auto_clear;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_RETRY && done && cnt_ff < RETRY_LIMIT)
      |=> (FAULT_IND_N && RETRY_COUNT == $past(cnt_ff) + 1'b1);
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("retry did not auto-clear");

  property p_report;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_IDLE && LOCK_DET && is_report)
      |=> (!FAULT_IND_N && DRIVE_CMD == DRV_NORMAL);
  endproperty
  a_report: assert property (p_report) else $error("report mode acted on stage");

  property p_disabled;
    @(posedge CLK) disable iff (!RESET_N)
      (state_ff == ST_IDLE && stall_response_select > SEL_REPORT) |=> FAULT_IND_N;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled code raised fault");

  property p_fields;
    @(posedge CLK) disable iff (!RESET_N)
      CFG_WR |=> (stall_response_select == $past(CFG_WDATA[6:3])
                  && lock_retry_interval == $past(CFG_WDATA[10:7]));
  endproperty
  a_fields: assert property (p_fields) else $error("config fields misplaced");

  c_latched: cover property (@(posedge CLK) disable iff (!RESET_N) state_ff == ST_LATCHED);
  c_retry_ok: cover property (@(posedge CLK) disable iff (!RESET_N)
    state_ff == ST_RETRY && done && cnt_ff < RETRY_LIMIT);
  c_report: cover property (@(posedge CLK) disable iff (!RESET_N) state_ff == ST_REPORT);
endmodule : mlfr_top

// file: verification/mlfr_bridge_model.sv
`timescale 1ns/1ns
module mlfr_bridge_model
  import mlfr_pkg::*;
(
  input wire mlfr_drive_t drive_cmd, // Command from the block
  output logic [5:0] gate_on, // High sides 5..3, low sides 2..0
  output logic floating // All switches open
);
  // Gate pattern per command; recirculation shown as no gate on
  always_comb
  begin
    gate_on = 6'h00;
    floating = 1'b0;
    case (drive_cmd)
      DRV_HS_BRAKE: gate_on = 6'h38; // High sides on
      DRV_LS_BRAKE: gate_on = 6'h07; // Low sides on
      DRV_HIZ: floating = 1'b1; // Everything open
      default: gate_on = 6'h00; // Run or recirculate
    endcase
  end
endmodule : mlfr_bridge_model

// file: verification/mlfr_bench.sv
`timescale 1ns/1ns
module mlfr_bench
  import mlfr_pkg::*;
;
  localparam int H = 4; // Short half-second keeps the run brief
  logic clk = 1'b0; // System clock
  logic reset_n = 1'b0; // Reset, low
  logic cfg_wr = 1'b0; // Config strobe
  logic [31:0] cfg_wdata = 32'h0; // Config data
  logic [31:0] cfg_rdata; // Config read-back
  logic [2:0] retry_limit = 3'h1; // One retry before latching
  logic lock_det = 1'b0; // Lock event
  logic fault_clr = 1'b0; // Latch clear
  logic fault_ind_n; // Fault indicator
  mlfr_drive_t drive_cmd; // Stage command
  mlfr_status_t status; // Status bundle
  logic [2:0] retry_count; // Retries taken
  logic [5:0] gate_on; // Bridge gates
  logic floating; // Bridge open
  int n_mismatch = 0; // Mismatches
  int checks = 0; // Comparisons
  // Expected stage per code, latched then retrying groups
  localparam mlfr_drive_t DRV [4] = '{DRV_HIZ, DRV_RECIRC, DRV_HS_BRAKE, DRV_LS_BRAKE};
  localparam logic [5:0] GATE [4] = '{6'h00, 6'h00, 6'h38, 6'h07};
  localparam logic FLT [4] = '{1'b1, 1'b0, 1'b0, 1'b0}; // Only tristate opens the bridge
  localparam logic [3:0] IVL [4] = '{4'h1, 4'h2, 4'h3, 4'hf};

  always #4 clk = ~clk;

  mlfr_top #(.HALF_CYC(H), .LIMIT_W(3)) u_dut (.CLK(clk), .RESET_N(reset_n), .CFG_WR(cfg_wr),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .RETRY_LIMIT(retry_limit),
    .LOCK_DET(lock_det), .FAULT_CLR(fault_clr), .FAULT_IND_N(fault_ind_n),
    .DRIVE_CMD(drive_cmd), .STATUS(status), .RETRY_COUNT(retry_count));
  mlfr_bridge_model u_bridge (.drive_cmd(drive_cmd), .gate_on(gate_on), .floating(floating));

  // Verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Value compare, four-state exact
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Bounded wait on the indicator; a miss ends the run
  task automatic wait_fault(input logic lvl, input int lim);
    int i;
    i = 0;
    while (fault_ind_n !== lvl && i < lim)
    begin
      cyc(1);
      i++;
    end
    chk("fault wait", lvl, fault_ind_n);
    if (fault_ind_n !== lvl)
      complete_run();
  endtask : wait_fault

  task automatic cfg_write(input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask : cfg_write

  // Short lock event, then back to quiet
  task automatic trip;
    lock_det = 1'b1;
    wait_fault(1'b0, 4);
    lock_det = 1'b0;
  endtask : trip

  task automatic clear_latch;
    fault_clr = 1'b1;
    cyc(1);
    fault_clr = 1'b0;
    cyc(1);
  endtask : clear_latch

  // Reset state and field masking
  task automatic t_config;
    chk("rdata reset", 32'h0, cfg_rdata);
    chk("fault reset", 32'h1, fault_ind_n);
    chk("drive reset", DRV_NORMAL, drive_cmd);
    chk("status reset", 32'h0, status);
    chk("count reset", 32'h0, retry_count);
    cfg_write(32'hffff_ffff);
    chk("rdata mask", 32'h0000_07f8, cfg_rdata);
  endtask : t_config

  // Codes 0..3 latch until cleared
  task automatic t_latched;
    for (int c = 0; c < 4; c++)
    begin
      cfg_write(32'(c) << 3);
      trip();
      cyc(20);
      chk("latch drive", DRV[c], drive_cmd);
      chk("latch gates", GATE[c], gate_on);
      chk("latch float", FLT[c], floating);
      chk("latch held", 32'h0, fault_ind_n);
      chk("latch flag", 32'h1, status.latched);
      clear_latch();
      chk("cleared", 32'h1, fault_ind_n);
    end
  endtask : t_latched

  // Codes 4..7 retry once, then latch
  task automatic t_retry;
    int t;
    for (int c = 0; c < 4; c++)
    begin
      t = (IVL[c] == 4'h1) ? H : 2 * (int'(IVL[c]) - 1) * H;
      cfg_write({21'h0, IVL[c], 4'(c + 4), 3'h0});
      trip();
      chk("retry drive", DRV[c], drive_cmd);
      chk("retrying", 32'h1, status.retrying);
      chk("retry float", FLT[c], floating);
      cyc(t - 1);
      chk("interval hold", 32'h0, fault_ind_n);
      wait_fault(1'b1, 8);
      chk("retry count", 32'h1, retry_count);
      chk("released", DRV_NORMAL, drive_cmd);
      trip();
      cyc(t + 8);
      chk("limit latch", 32'h1, status.latched);
      chk("limit drive", DRV[c], drive_cmd);
      chk("limit fault", 32'h0, fault_ind_n);
      clear_latch();
      chk("count clear", 32'h0, retry_count);
    end
  endtask : t_retry

  // Code 8 reports only
  task automatic t_report;
    cfg_write(32'h40);
    lock_det = 1'b1;
    wait_fault(1'b0, 4);
    cyc(5);
    chk("report drive", DRV_NORMAL, drive_cmd);
    chk("reporting", 32'h1, status.reporting);
    chk("report fault", 32'h1, status.fault);
    chk("report gates", 32'h0, gate_on);
    lock_det = 1'b0;
    wait_fault(1'b1, 4);
  endtask : t_report

  // Codes 9..F ignore the lock input
  task automatic t_disabled;
    for (int c = 9; c < 16; c++)
    begin
      cfg_write(32'(c) << 3);
      lock_det = 1'b1;
      cyc(6);
      chk("disabled fault", 32'h1, fault_ind_n);
      chk("disabled drive", DRV_NORMAL, drive_cmd);
      lock_det = 1'b0;
    end
  endtask : t_disabled

  // Zero limit latches at first expiry; reserved interval acts as 500 ms
  // Then a reset in mid-run must drop the latch and the config
  task automatic t_limit_reset;
    retry_limit = 3'h0;
    cfg_write({21'h0, 4'h0, SEL_RETRY_LSB, 3'h0});
    trip();
    cyc(H + 8);
    chk("zero limit latch", 32'h1, status.latched);
    chk("zero limit count", 32'h0, retry_count);
    chk("zero limit gates", 32'h07, gate_on);
    reset_n = 1'b0;
    cyc(2);
    chk("reset fault", 32'h1, fault_ind_n);
    chk("reset cfg", 32'h0, cfg_rdata);
    reset_n = 1'b1;
    cyc(2);
    chk("reset drive", DRV_NORMAL, drive_cmd);
    chk("reset status", 32'h0, status);
  endtask : t_limit_reset

  // Main sequence
  initial
  begin
    cyc(16);
    reset_n = 1'b1;
    cyc(1);
    t_config();
    t_latched();
    t_retry();
    t_report();
    t_disabled();
    t_limit_reset();
    complete_run();
  end
endmodule : mlfr_bench
